// ==== design/interrupt_source_vector_map_regs.svh ====
// Constants of the interrupt source to vector mapping block.
// Assumes inclusion by bare name from the block package user.
`ifndef INTERRUPT_SOURCE_VECTOR_MAP_REGS_SVH
`define INTERRUPT_SOURCE_VECTOR_MAP_REGS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define IRQ_COUNT 39
`define VECTOR_COUNT 32
`define FLAG_WORD_WIDTH 32
`define FLAG_ONE_USED 7
`define PRIORITY_WORD_COUNT 8

// ----------------------------------------------------------------------
// Field positions inside a priority word
// ----------------------------------------------------------------------
`define VECTORS_PER_WORD 4
`define VECTOR_FIELD_STRIDE 8
`define PRIORITY_LSB 2
`define PRIORITY_WIDTH 3
`define SUBPRIORITY_LSB 0
`define SUBPRIORITY_WIDTH 2

// ----------------------------------------------------------------------
// Source properties
// ----------------------------------------------------------------------
`define PERSISTENT_MASK 39'h78_1631_8C60
`define PRESENT_ALL 39'h7F_FFFF_FFFF

`endif

// ==== design/interrupt_source_vector_map_pkg.sv ====
// Types of the interrupt source to vector mapping block.
// Assumes the constants header is on the include path.
`default_nettype none
package interrupt_source_vector_map_pkg;
    `include "interrupt_source_vector_map_regs.svh"

    typedef logic [4:0] vector_type;
    typedef logic [2:0] level_type;
    typedef logic [1:0] sublevel_type;
    typedef logic [`IRQ_COUNT-1:0] irq_set_type;
    typedef logic [`VECTOR_COUNT-1:0] vector_set_type;
    typedef logic [31:0] word_type;
endpackage : interrupt_source_vector_map_pkg
`default_nettype wire

// ==== design/interrupt_source_vector_map.sv ====
// Interrupt flag, enable and vector selection logic.
// Assumes sources are synchronous to clock_i; configuration words are plain ports.
//
// Contract
// - Core timer is request 0 on vector 0, flag and enable bit 0, priority 4:2 and sub 1:0.
// - Two core software requests are requests 1 and 2 on vectors 1 and 2, non-persistent.
// - External pin requests 3, 8, 13, 18, 23 go to vectors 3, 7, 11, 15, 19, non-persistent.
// - Timer requests 4, 9, 14, 19, 24 go to vectors 4, 8, 12, 16, 20, non-persistent.
// - Each capture unit's error and event requests share one vector and are persistent.
// - Compare requests 7, 12, 17, 22, 27 go to vectors 6, 10, 14, 18, 22, non-persistent.
// - Conversion done is request 28 on vector 23 and is persistent.
// - Requests 29, 30, 31 go to vectors 24, 25, 26 and are non-persistent.
// - Comparator requests 32, 33, 34 go to vectors 27, 28, 29 at bits 0-2 of the second words.
// - USB request is 35 on vector 30 with priority in bits 20:18 of word seven, persistent.
// - Serial port requests 36, 37, 38 share vector 31, priority 28:26 of word seven, persistent.
// - Requests 0-31 sit at their own bit of the first words, 32 onward from bit 0 of the second.
// - Each priority word holds four vectors, priority at 8k+4:8k+2, sub at 8k+1:8k.
// - Source presence is configurable while numbering stays fixed.
`timescale 1ns/100ps
`default_nettype none

module interrupt_source_vector_map #(
    parameter logic [38:0] SOURCE_PRESENT = 39'h7F_FFFF_FFFF
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Request lines, bit index is the request number
    input wire interrupt_source_vector_map_pkg::irq_set_type source_request_i,
    // Flag clear strobes from software
    input wire interrupt_source_vector_map_pkg::word_type flag_clear_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type flag_clear_word_one_i,
    // Enable words
    input wire interrupt_source_vector_map_pkg::word_type enable_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type enable_word_one_i,
    // Priority words
    input wire interrupt_source_vector_map_pkg::word_type priority_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_one_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_two_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_three_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_four_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_five_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_six_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_seven_i,
    // Flag status
    output var interrupt_source_vector_map_pkg::word_type flag_word_zero_o,
    output var interrupt_source_vector_map_pkg::word_type flag_word_one_o,
    // Request to the core
    output var logic core_request_o,
    output var interrupt_source_vector_map_pkg::vector_type core_vector_o,
    output var interrupt_source_vector_map_pkg::level_type core_priority_o,
    output var interrupt_source_vector_map_pkg::sublevel_type core_subpriority_o
);
    import interrupt_source_vector_map_pkg::*;

    // ------------------------------------------------------------------
    // Source to vector table
    // ------------------------------------------------------------------
    function automatic vector_type irq_vector(input int unsigned irq);
        vector_type v;
        // Request number selects its fixed vector
        case (irq)
            0: v = 5'h00;
            1: v = 5'h01;
            2: v = 5'h02;
            3: v = 5'h03;
            4: v = 5'h04;
            5, 6: v = 5'h05;
            7: v = 5'h06;
            8: v = 5'h07;
            9: v = 5'h08;
            10, 11: v = 5'h09;
            12: v = 5'h0A;
            13: v = 5'h0B;
            14: v = 5'h0C;
            15, 16: v = 5'h0D;
            17: v = 5'h0E;
            18: v = 5'h0F;
            19: v = 5'h10;
            20, 21: v = 5'h11;
            22: v = 5'h12;
            23: v = 5'h13;
            24: v = 5'h14;
            25, 26: v = 5'h15;
            27: v = 5'h16;
            28: v = 5'h17;
            29: v = 5'h18;
            30: v = 5'h19;
            31: v = 5'h1A;
            32: v = 5'h1B;
            33: v = 5'h1C;
            34: v = 5'h1D;
            35: v = 5'h1E;
            default: v = 5'h1F;
        endcase
        return v;
    endfunction : irq_vector

    // Pending enabled sources folded onto their vectors
    function automatic vector_set_type fold_pending(input irq_set_type active);
        vector_set_type p;
        p = '0;
        // Shared vectors collect several requests
        for (int i = 0; i < `IRQ_COUNT; i++) begin
            if (active[i]) begin
                p[irq_vector(i)] = 1'b1;
            end
        end
        return p;
    endfunction : fold_pending

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // Flag state and decode nets
    irq_set_type flag_ff;
    irq_set_type nxt_flag;
    irq_set_type source_prev_ff;
    irq_set_type persistent;
    irq_set_type present;
    irq_set_type set_event;
    irq_set_type clear_req;
    irq_set_type enable_all;

    // Presence gate and persistence map
    assign present = SOURCE_PRESENT & `PRESENT_ALL;
    assign persistent = `PERSISTENT_MASK;
    // Flag words packed by request number
    assign clear_req = {flag_clear_word_one_i[`FLAG_ONE_USED-1:0], flag_clear_word_zero_i};
    assign enable_all = {enable_word_one_i[`FLAG_ONE_USED-1:0], enable_word_zero_i};
    // Level for persistent, rising edge otherwise
    assign set_event = present & source_request_i
        & (persistent | ~source_prev_ff);
    // Set wins over a clear in the same cycle
    assign nxt_flag = set_event | (flag_ff & ~clear_req & present);

    // Cleared history turns a source high at release into a new event
    // Flag and edge history registers
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_ff <= '0;
            source_prev_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
            source_prev_ff <= source_request_i;
        end
    end

    // ------------------------------------------------------------------
    // Flag status
    // ------------------------------------------------------------------
    // Flag status straight from the flag register
    assign flag_word_zero_o = flag_ff[`FLAG_WORD_WIDTH-1:0];
    assign flag_word_one_o = {25'h0, flag_ff[`IRQ_COUNT-1:`FLAG_WORD_WIDTH]};

    // ------------------------------------------------------------------
    // Priority fields and selection
    // ------------------------------------------------------------------
    // Priority words and per-vector keys
    word_type prio_words [`PRIORITY_WORD_COUNT];
    vector_set_type vector_pending;
    logic [4:0] vec_key [`VECTOR_COUNT];

    // Priority word array
    assign prio_words[0] = priority_word_zero_i;
    assign prio_words[1] = priority_word_one_i;
    assign prio_words[2] = priority_word_two_i;
    assign prio_words[3] = priority_word_three_i;
    assign prio_words[4] = priority_word_four_i;
    assign prio_words[5] = priority_word_five_i;
    assign prio_words[6] = priority_word_six_i;
    assign prio_words[7] = priority_word_seven_i;

    // Per-vector priority and subpriority key
    for (genvar v = 0; v < `VECTOR_COUNT; v++) begin : g_key
        localparam int BASE = (v % `VECTORS_PER_WORD) * `VECTOR_FIELD_STRIDE;
        assign vec_key[v] = {
            prio_words[v / `VECTORS_PER_WORD][BASE + `PRIORITY_LSB +: `PRIORITY_WIDTH],
            prio_words[v / `VECTORS_PER_WORD][BASE + `SUBPRIORITY_LSB +: `SUBPRIORITY_WIDTH]
        };
    end

    // Enabled flags folded onto vectors
    assign vector_pending = fold_pending(flag_ff & enable_all);

    // Selection result of the current cycle
    logic pick_found;
    vector_type pick_vector;
    logic [4:0] pick_key;

    // Highest key wins, strict compare keeps the lowest vector on ties
    always_comb begin
        pick_found = 1'b0;
        pick_vector = 5'h00;
        pick_key = 5'h00;
        for (int v = 0; v < `VECTOR_COUNT; v++) begin
            if (vector_pending[v] && (!pick_found || vec_key[v] > pick_key)) begin
                pick_found = 1'b1;
                pick_vector = 5'(v);
                pick_key = vec_key[v];
            end
        end
    end

    // ------------------------------------------------------------------
    // Request to the core
    // ------------------------------------------------------------------
    // Registered request towards the core
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_request_o <= 1'b0;
            core_vector_o <= 5'h00;
            core_priority_o <= 3'h0;
            core_subpriority_o <= 2'h0;
        end else begin
            core_request_o <= pick_found;
            core_vector_o <= pick_vector;
            core_priority_o <= pick_key[4:2];
            core_subpriority_o <= pick_key[1:0];
        end
    end
endmodule : interrupt_source_vector_map

`default_nettype wire

// ==== test/peripheral_source_model.sv ====
// Peripheral side model driving the request lines.
// Assumes hold_i changes away from the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module peripheral_source_model (
    // Clock
    input wire logic clock_i,
    // Event conditions
    input wire interrupt_source_vector_map_pkg::irq_set_type hold_i,
    // Request lines
    output var interrupt_source_vector_map_pkg::irq_set_type source_request_o
);
    import interrupt_source_vector_map_pkg::*;
    // Lines launch on the clock, as on-chip peripherals do
    initial source_request_o = '0;
    always @(posedge clock_i) begin
        source_request_o <= hold_i;
    end
endmodule : peripheral_source_model
`default_nettype wire

// ==== test/interrupt_source_vector_map_chk.sv ====
// Port checker for the source to vector block.
// Assumes it is bound onto the block.
`timescale 1ns/100ps
`default_nettype none
module interrupt_source_vector_map_chk (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Inputs
    input wire interrupt_source_vector_map_pkg::irq_set_type source_request_i,
    input wire interrupt_source_vector_map_pkg::word_type flag_clear_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type enable_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type enable_word_one_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_zero_i,
    input wire interrupt_source_vector_map_pkg::word_type priority_word_seven_i,
    // Outputs
    input wire interrupt_source_vector_map_pkg::word_type flag_word_zero_o,
    input wire interrupt_source_vector_map_pkg::word_type flag_word_one_o,
    input wire logic core_request_o,
    input wire interrupt_source_vector_map_pkg::vector_type core_vector_o,
    input wire interrupt_source_vector_map_pkg::level_type core_priority_o,
    input wire interrupt_source_vector_map_pkg::sublevel_type core_subpriority_o
);
    import interrupt_source_vector_map_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // Some enabled flag pending
    wire logic pend = |(flag_word_zero_o & enable_word_zero_i)
        | |(flag_word_one_o[6:0] & enable_word_one_i[6:0]);
    sequence s_new4; !source_request_i[4] ##1 source_request_i[4]; endsequence
    sequence s_new32; !source_request_i[32] ##1 source_request_i[32]; endsequence
    property p_timer_set; s_new4 |=> flag_word_zero_o[4]; endproperty
    property p_persist; source_request_i[6] |=> flag_word_zero_o[6]; endproperty
    property p_np_cause;
        $rose(flag_word_zero_o[3]) |-> $past(source_request_i[3])
            && !$past(source_request_i[3], 2);
    endproperty
    property p_comp_set; s_new32 |=> flag_word_one_o[0]; endproperty
    property p_upper_zero; flag_word_one_o[31:7] == 25'h0; endproperty
    property p_clear;
        flag_clear_word_zero_i[4] && !source_request_i[4] |=> !flag_word_zero_o[4];
    endproperty
    property p_core_req; core_request_o == $past(pend); endproperty
    property p_timer_fields;
        core_request_o && core_vector_o == 5'h00
            |-> core_priority_o == $past(priority_word_zero_i[4:2])
            && core_subpriority_o == $past(priority_word_zero_i[1:0]);
    endproperty
    property p_spi_fields;
        core_request_o && core_vector_o == 5'h1F
            |-> core_priority_o == $past(priority_word_seven_i[28:26]);
    endproperty
    a_timer_set: assert property (p_timer_set) else $error("timer flag not set");
    a_persist: assert property (p_persist) else $error("persistent flag lost");
    a_np_cause: assert property (p_np_cause) else $error("pin flag set without edge");
    a_comp_set: assert property (p_comp_set) else $error("comparator flag misplaced");
    a_upper_zero: assert property (p_upper_zero) else $error("unused flag bits set");
    a_clear: assert property (p_clear) else $error("flag not cleared");
    a_core_req: assert property (p_core_req) else $error("core request wrong");
    a_timer_fields: assert property (p_timer_fields) else $error("timer fields wrong");
    a_spi_fields: assert property (p_spi_fields) else $error("serial fields wrong");
endmodule : interrupt_source_vector_map_chk
bind interrupt_source_vector_map interrupt_source_vector_map_chk u_chk (.clock_i, .rst_b_i,
    .source_request_i, .flag_clear_word_zero_i, .enable_word_zero_i, .enable_word_one_i,
    .priority_word_zero_i, .priority_word_seven_i, .flag_word_zero_o, .flag_word_one_o,
    .core_request_o, .core_vector_o, .core_priority_o, .core_subpriority_o);
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the source to vector block.
// Assumes package, checker and source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import interrupt_source_vector_map_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    irq_set_type hold_mask = '0;
    irq_set_type src;
    word_type clr0 = '0, clr1 = '0, en0 = '0, en1 = '0, flag0, flag1;
    word_type pw [8] = '{default: '0};
    logic core_req, last_req = 1'b0;
    vector_type core_vec, last_vec = '0;
    level_type core_prio;
    sublevel_type core_sub;
    logic [9:0] exp_q [$];
    int bad_count = 0;
    int tests_run = 0;
    int vmap [39] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 9, 10, 11, 12, 13, 13, 14, 15, 16,
        17, 17, 18, 19, 20, 21, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 31, 31};
    localparam logic [38:0] PERSIST = 39'h78_1631_8C60;
    always #12.5 clock_i = ~clock_i;
    peripheral_source_model u_peripheral_source_model (.clock_i(clock_i), .hold_i(hold_mask),
        .source_request_o(src));
    interrupt_source_vector_map u_interrupt_source_vector_map (.clock_i(clock_i),
        .rst_b_i(rst_b_i), .source_request_i(src), .flag_clear_word_zero_i(clr0),
        .flag_clear_word_one_i(clr1), .enable_word_zero_i(en0), .enable_word_one_i(en1),
        .priority_word_zero_i(pw[0]), .priority_word_one_i(pw[1]), .priority_word_two_i(pw[2]),
        .priority_word_three_i(pw[3]), .priority_word_four_i(pw[4]),
        .priority_word_five_i(pw[5]), .priority_word_six_i(pw[6]),
        .priority_word_seven_i(pw[7]), .flag_word_zero_o(flag0), .flag_word_one_o(flag1),
        .core_request_o(core_req), .core_vector_o(core_vec), .core_priority_o(core_prio),
        .core_subpriority_o(core_sub));
    // Compare and count
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Flag compare and count
    task automatic chk_flag(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_flag
    // One flag bit by request number
    function automatic logic flag_at(input int n);
        logic [63:0] f;
        f = {flag1, flag0};
        return f[n];
    endfunction : flag_at
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #2;
    endtask : tick
    // Expected vector and fields from the bench's own copy of the words
    function automatic logic [9:0] expect_of(input int v);
        word_type w;
        w = pw[v / 4] >> (8 * (v % 4));
        return {v[4:0], w[4:2], w[1:0]};
    endfunction : expect_of
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // Result watcher, oldest note first
    always @(posedge clock_i) begin
        if (rst_b_i && core_req && (!last_req || core_vec !== last_vec)) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("[ERR] core_extra expected none seen %h",
                    {core_vec, core_prio, core_sub});
            end else begin
                chk("core", exp_q.pop_front(), {core_vec, core_prio, core_sub});
            end
        end
        last_req <= core_req;
        last_vec <= core_vec;
    end
    // Main sequence
    initial begin
        void'($urandom(95));
        tick(16);
        rst_b_i = 1'b1;
        for (int n = 0; n < 39; n++) begin
            foreach (pw[i]) pw[i] = $urandom;
            {en1, en0} = 64'h1 << n;
            exp_q.push_back(expect_of(vmap[n]));
            hold_mask = 39'h1 << n;
            tick(4);
            chk_flag("flag", 1'b1, flag_at(n));
            {clr1, clr0} = 64'h1 << n;
            tick(2);
            chk_flag("flag_held", PERSIST[n], flag_at(n));
            hold_mask = '0;
            tick(2);
            {clr1, clr0} = '0;
            tick(2);
            $display("request %0d done", n);
        end
        // Equal levels, then a raised level on the higher vector
        foreach (pw[i]) pw[i] = '0;
        {en1, en0} = 64'h0000_0000_0000_0210;
        exp_q.push_back(10'h080);
        hold_mask = 39'h00_0000_0210;
        tick(4);
        pw[2] = 32'h0000_001C;
        exp_q.push_back(10'h11C);
        tick(3);
        hold_mask = '0;
        $display("tie test done");
        tick(2);
        chk("queue_left", 10'h000, 10'(exp_q.size()));
        report_and_stop();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge clock_i);
        bad_count++;
        $display("[ERR] watchdog expected end seen timeout");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
